// ==== include/subword_alt_pkg.sv ====
// Purpose: shared types and constants for the sub-word indirection and augment stage
// Assumes: opcodes arrive already classified by the fetch side
// Notes:   field positions are those of the operand values, not of the instruction word
package subword_alt_pkg;

	// ==========================================================
	// field positions of the operand values
	localparam int BASE_LSB      = 0;    // base register address in src
	localparam int BASE_W        = 9;    // register address width
	localparam int INDEX_LSB     = 9;    // signed auto-index in src
	localparam int INDEX_W       = 9;    // auto-index width
	localparam int AUG_LSB       = 9;    // augment bits start above the 9-bit field
	localparam int AUG_W         = 23;   // queued augment width
	localparam int BYTE_SEL_W    = 2;    // byte selector width
	localparam int NIB_SEL_W     = 3;    // nibble selector width
	localparam int WORD_SEL_W    = 1;    // word selector width
	localparam int BYTE_PTR_W    = 11;   // byte pointer width
	localparam int NIB_PTR_W     = 12;   // nibble pointer width
	localparam int WORD_PTR_W    = 10;   // word pointer width
	localparam int DATA_W        = 32;   // register width

	// ==========================================================
	// timing and reset values
	localparam int         ALT_CYCLES = 2;      // core cycles per indirection op
	localparam logic [8:0] ADDR_RST   = 9'h000; // register address after reset
	localparam logic [2:0] SEL_RST    = 3'h0;   // selector after reset

	// ==========================================================
	// classified operations
	typedef enum logic [2:0] {
		OP_OTHER,               // any instruction this stage does not act on
		OP_ALTER_BYTE,          // alter_byte_target
		OP_ALTER_NIBBLE,        // alter_nibble_target
		OP_ALTER_WORD,          // alter_word_target
		OP_EXTEND_DEST,         // extend_dest_literal
		OP_LOAD_Q               // load_pending_q or load_pending_q_alt
	} op_e;

	// sub-field kind seen by execute
	typedef enum logic [1:0] {FLD_NONE, FLD_BYTE, FLD_NIBBLE, FLD_WORD} field_e;

	// stage execution phase
	typedef enum logic {PH_ISSUE, PH_EXEC} phase_e;

	// instruction as handed over by fetch
	typedef struct packed {
		op_e         op;          // classified operation
		logic        singleForm;  // single-operand syntax
		logic        usesLitDest; // dest field is a literal
		logic [8:0]  destAddr;    // encoded dest register address
		logic [8:0]  destField;   // raw 9-bit dest field
		logic [31:0] destVal;     // value read from dest
		logic [31:0] srcVal;      // value of src (register or literal)
	} instr_s;

	// instruction as handed to execute
	typedef struct packed {
		logic [8:0]  regAddr;     // dest register address, possibly altered
		logic        altered;     // address and selector were substituted
		logic [2:0]  sel;         // sub-field selector
		field_e      kind;        // sub-field kind of the selector
		logic [4:0]  shift;       // bit offset of the sub-field
		logic [31:0] destLit;     // dest literal, possibly augmented
		logic        qValid;      // pending q accompanies this instruction
		logic [31:0] qVal;        // pending q value
	} exec_s;

	// pointer write-back to the register file
	typedef struct packed {
		logic        valid;       // one-cycle write strobe
		logic [8:0]  addr;        // dest register address
		logic [31:0] data;        // post-adjusted pointer
	} wb_s;

endpackage

// ==== core/subword_alt_stage.sv ====
// Purpose: front-end stage that retargets the next instruction and augments literal dests
// Assumes: one core clock, fetch holds its request until accepted, q value given with load
// Notes:   all outputs registered; one cycle of latency from issue to execute
`timescale 1ns/1ps

module subword_alt_stage
	import subword_alt_pkg::*;
(
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst,
	// issue from fetch
	input  wire logic   issueValid,
	input  wire instr_s issueInstr,
	output logic        issueReady,
	// hand-over to execute
	output logic        execValid,
	output exec_s       execInstr,
	// pointer write-back
	output wb_s         wbOut,
	// interrupt shield
	output logic        irqBlock
);

	// ==========================================================
	// state
	typedef struct packed {
		phase_e      phase;       // issue or second exec cycle
		instr_s      cur;         // indirection op in execution
		logic        subValid;    // substitution pending for next instr
		logic [8:0]  subAddr;     // substituted register address
		logic [2:0]  subSel;      // substituted selector
		field_e      subKind;     // substituted field kind
		logic [4:0]  subShift;    // substituted bit offset
		logic        augValid;    // augment queue full
		logic [22:0] augVal;      // queued upper literal bits
		logic        qValid;      // pending q held
		logic [31:0] qVal;        // pending q value
		logic        ready;       // issue ready
		logic        execValid;   // execute strobe
		exec_s       exec;        // execute payload
		wb_s         wb;          // write-back payload
		logic        irqBlock;    // interrupt shield
	} st_s;

	st_s state_r;                 // registered state
	st_s state_nxt;               // next state

	// ==========================================================
	// target decode of the op in execution
	logic [8:0]  longIdx;         // long index taken from dest
	logic [2:0]  tgtSel;          // selector taken from dest
	logic [4:0]  tgtShift;        // bit offset of selected field
	field_e      tgtKind;         // field kind of the op
	logic [8:0]  tgtAddr;         // final register address
	logic [8:0]  autoIdx;         // signed index, zero in single form
	logic [31:0] ptrSum;          // post-adjusted pointer
	logic        take;            // request accepted this edge

	assign take = issueValid && state_r.ready;

	// field extraction per op kind
	always_comb begin
		longIdx  = 9'h000;
		tgtSel   = 3'h0;
		tgtShift = 5'h00;
		tgtKind  = FLD_NONE;
		case (state_r.cur.op)
			OP_ALTER_BYTE: begin
				longIdx  = state_r.cur.destVal[10:2];
				tgtSel   = {1'b0, state_r.cur.destVal[1:0]};
				tgtShift = {state_r.cur.destVal[1:0], 3'h0};
				tgtKind  = FLD_BYTE;
			end
			OP_ALTER_NIBBLE: begin
				longIdx  = state_r.cur.destVal[11:3];
				tgtSel   = state_r.cur.destVal[2:0];
				tgtShift = {state_r.cur.destVal[2:0], 2'h0};
				tgtKind  = FLD_NIBBLE;
			end
			OP_ALTER_WORD: begin
				longIdx  = state_r.cur.destVal[9:1];
				tgtSel   = {2'h0, state_r.cur.destVal[0]};
				tgtShift = {state_r.cur.destVal[0], 4'h0};
				tgtKind  = FLD_WORD;
			end
			default: begin
				// not an indirection op, decode unused
				longIdx  = 9'h000;
			end
		endcase
	end

	// address and pointer arithmetic
	always_comb begin
		// single form is absolute, no base
		if (state_r.cur.singleForm) begin
			tgtAddr = longIdx;
			autoIdx = 9'h000;
		end else begin
			// nine-bit sum wraps, which is the mask to the register space
			tgtAddr = state_r.cur.srcVal[BASE_LSB +: BASE_W] + longIdx;
			autoIdx = state_r.cur.srcVal[INDEX_LSB +: INDEX_W];
		end
		ptrSum = state_r.cur.destVal + {{23{autoIdx[8]}}, autoIdx};
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		state_nxt           = state_r;
		state_nxt.execValid = 1'b0;
		state_nxt.wb.valid  = 1'b0;
		case (state_r.phase)
			PH_ISSUE: begin
				if (take) begin
					case (issueInstr.op)
						OP_ALTER_BYTE, OP_ALTER_NIBBLE, OP_ALTER_WORD: begin
							state_nxt.phase = PH_EXEC;
							state_nxt.cur   = issueInstr;
							state_nxt.ready = 1'b0;
							state_nxt.qValid = state_r.qValid;
						end
						OP_EXTEND_DEST: begin
							state_nxt.augValid = 1'b1;
							state_nxt.augVal   = issueInstr.srcVal[AUG_LSB +: AUG_W];
						end
						OP_LOAD_Q: begin
							// q held for the next consuming instruction
							state_nxt.qValid = 1'b1;
							state_nxt.qVal   = issueInstr.destVal;
						end
						default: begin
							// ordinary instruction goes to execute
							state_nxt.execValid      = 1'b1;
							state_nxt.exec.regAddr   = issueInstr.destAddr;
							state_nxt.exec.altered   = 1'b0;
							state_nxt.exec.sel       = SEL_RST;
							state_nxt.exec.kind      = FLD_NONE;
							state_nxt.exec.shift     = 5'h00;
							state_nxt.exec.destLit   = {23'h000000, issueInstr.destField};
							state_nxt.exec.qValid    = state_r.qValid;
							state_nxt.exec.qVal      = state_r.qVal;
							state_nxt.qValid         = 1'b0;
							if (state_r.subValid) begin
								state_nxt.exec.regAddr = state_r.subAddr;
								state_nxt.exec.altered = 1'b1;
								state_nxt.exec.sel     = state_r.subSel;
								state_nxt.exec.kind    = state_r.subKind;
								state_nxt.exec.shift   = state_r.subShift;
							end
							state_nxt.subValid = 1'b0;
							// augment the first literal dest user
							if (state_r.augValid && issueInstr.usesLitDest) begin
								state_nxt.exec.destLit = {state_r.augVal,
									issueInstr.destField};
								state_nxt.augValid = 1'b0;
							end
						end
					endcase
				end
			end
			PH_EXEC: begin
				state_nxt.phase    = PH_ISSUE;
				state_nxt.ready    = 1'b1;
				state_nxt.wb.valid = 1'b1;
				state_nxt.wb.addr  = state_r.cur.destAddr;
				state_nxt.wb.data  = ptrSum;
				state_nxt.subValid = 1'b1;
				state_nxt.subAddr  = tgtAddr;
				state_nxt.subSel   = tgtSel;
				state_nxt.subKind  = tgtKind;
				state_nxt.subShift = tgtShift;
			end
			default: begin
				state_nxt.phase = PH_ISSUE;
			end
		endcase
		state_nxt.irqBlock = (state_nxt.phase == PH_EXEC) || state_nxt.subValid
			|| state_nxt.augValid;
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= '0;
			state_r.phase <= PH_ISSUE;
			state_r.ready <= 1'b1;
			state_r.exec.regAddr <= ADDR_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs straight from the state flops
	assign issueReady = state_r.ready;
	assign execValid  = state_r.execValid;
	assign execInstr  = state_r.exec;
	assign wbOut      = state_r.wb;
	assign irqBlock   = state_r.irqBlock;

	// ==========================================================
	// checks
	logic   altTake;              // indirection op accepted
	logic   augTake;              // augment op accepted
	assign altTake = take && (issueInstr.op inside {OP_ALTER_BYTE, OP_ALTER_NIBBLE,
		OP_ALTER_WORD});
	assign augTake = take && (issueInstr.op == OP_EXTEND_DEST);

	property p_wb_two;
		@(posedge clk) disable iff (rst) altTake |=> !wbOut.valid ##1 wbOut.valid;
	endproperty
	a_wb_two: assert property (p_wb_two) else $error("write-back not two cycles after op");

	property p_wb_sum;
		@(posedge clk) disable iff (rst) altTake && issueInstr.singleForm
			|-> ##2 wbOut.data == $past(issueInstr.destVal, 2);
	endproperty
	a_wb_sum: assert property (p_wb_sum) else $error("single form index not zero");

	property p_ready_low;
		@(posedge clk) disable iff (rst) altTake |=> !issueReady ##1 issueReady;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready not dropped one cycle");

	property p_irq_alt;
		@(posedge clk) disable iff (rst) altTake |=> irqBlock [*2];
	endproperty
	a_irq_alt: assert property (p_irq_alt) else $error("interrupt not shielded");

	property p_irq_aug;
		@(posedge clk) disable iff (rst) augTake |=> irqBlock;
	endproperty
	a_irq_aug: assert property (p_irq_aug) else $error("augment did not shield");

	property p_aug_lit;
		@(posedge clk) disable iff (rst) take && state_r.augValid
			&& issueInstr.usesLitDest && issueInstr.op == OP_OTHER
			|=> execValid && execInstr.destLit[31:9] == $past(state_r.augVal);
	endproperty
	a_aug_lit: assert property (p_aug_lit) else $error("augment bits not applied");

	property p_aug_clear;
		@(posedge clk) disable iff (rst) take && state_r.augValid
			&& issueInstr.usesLitDest && issueInstr.op == OP_OTHER |=> !state_r.augValid;
	endproperty
	a_aug_clear: assert property (p_aug_clear) else $error("augment queue not cleared");

	property p_irq_hold;
		@(posedge clk) disable iff (rst) state_r.augValid |-> irqBlock;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("shield dropped before use");

	property p_sub_once;
		@(posedge clk) disable iff (rst) take && state_r.subValid && issueInstr.op == OP_OTHER
			|=> execInstr.altered ##0 !state_r.subValid;
	endproperty
	a_sub_once: assert property (p_sub_once) else $error("substitution not single use");

	property p_q_pass;
		@(posedge clk) disable iff (rst) altTake && state_r.qValid |=> state_r.qValid [*2];
	endproperty
	a_q_pass: assert property (p_q_pass) else $error("q lost across indirection");

	// alter ops stay inside this stage, execute never sees them
	property p_alt_no_exec;
		@(posedge clk) disable iff (rst) altTake |=> !execValid;
	endproperty
	a_alt_no_exec: assert property (p_alt_no_exec) else $error("alter op sent on");

	// adjusted pointer goes back to the op's own dest register
	property p_wb_addr;
		@(posedge clk) disable iff (rst) altTake
			|-> ##2 wbOut.addr == $past(issueInstr.destAddr, 2);
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write-back address wrong");

	// byte position is one of four, eight bits a step
	property p_byte_sel;
		@(posedge clk) disable iff (rst) execValid && execInstr.kind == FLD_BYTE
			|-> execInstr.sel[2] == 1'b0 && execInstr.shift == {execInstr.sel[1:0], 3'h0};
	endproperty
	a_byte_sel: assert property (p_byte_sel) else $error("byte position wrong");

	// nibble position counts upward, four bits a step
	property p_nib_shift;
		@(posedge clk) disable iff (rst) execValid && execInstr.kind == FLD_NIBBLE
			|-> execInstr.shift == {execInstr.sel, 2'h0};
	endproperty
	a_nib_shift: assert property (p_nib_shift) else $error("nibble position wrong");

	// word selector picks the low or the high half only
	property p_word_sel;
		@(posedge clk) disable iff (rst) execValid && execInstr.kind == FLD_WORD
			|-> execInstr.sel[2:1] == 2'h0 && execInstr.shift == {execInstr.sel[0], 4'h0};
	endproperty
	a_word_sel: assert property (p_word_sel) else $error("word half wrong");

	// an empty queue leaves the literal zero-extended
	property p_lit_plain;
		@(posedge clk) disable iff (rst) take && !state_r.augValid && issueInstr.op == OP_OTHER
			|=> execInstr.destLit[31:9] == 23'h0;
	endproperty
	a_lit_plain: assert property (p_lit_plain) else $error("stale augment applied");

	// nothing pending: the instruction keeps its own address
	property p_own_addr;
		@(posedge clk) disable iff (rst) take && !state_r.subValid && issueInstr.op == OP_OTHER
			|=> !execInstr.altered && execInstr.regAddr == $past(issueInstr.destAddr);
	endproperty
	a_own_addr: assert property (p_own_addr) else $error("address altered twice");

	c_alt_then_use: cover property (@(posedge clk) disable iff (rst)
		altTake ##2 (take && issueInstr.op == OP_OTHER) ##1 execInstr.altered);
	c_aug_use: cover property (@(posedge clk) disable iff (rst)
		augTake ##[1:4] (take && issueInstr.usesLitDest));
	c_q_pass: cover property (@(posedge clk) disable iff (rst)
		state_r.qValid && altTake ##3 execInstr.qValid);
	c_alt_single: cover property (@(posedge clk) disable iff (rst)
		altTake && issueInstr.singleForm ##2 wbOut.valid);

endmodule

// ==== verif/exec_model.sv ====
// Purpose: execute-side partner that records what the stage hands over
// Assumes: execValid and wbOut.valid are one-cycle pulses on the core clock
// Notes:   keeps only the latest payload and a running count of each pulse
`timescale 1ns/1ps

module exec_model
	import subword_alt_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// stage outputs
	input  wire logic  execValid,
	input  wire exec_s execInstr,
	input  wire wb_s   wbOut,
	// captured results
	output exec_s      lastExec,
	output wb_s        lastWb,
	output logic [7:0] execCount,
	output logic [7:0] wbCount
);
	// ==========================================================
	// capture
	// a pulse is taken on the edge where it stands, as execute would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lastExec  <= '0;
			lastWb    <= '0;
			execCount <= 8'h00;
			wbCount   <= 8'h00;
		end else begin
			// instruction handed to execute
			if (execValid) begin
				lastExec  <= execInstr;
				execCount <= execCount + 8'h01;
			end
			// pointer write into the register file
			if (wbOut.valid) begin
				lastWb  <= wbOut;
				wbCount <= wbCount + 8'h01;
			end
		end
	end
endmodule

// ==== verif/subword_alt_stage_tb.sv ====
// Purpose: self-checking bench for the retarget and augment stage
// Assumes: inputs change at the falling edge, outputs read at the falling edge
// Notes:   table rows cover each indirection op; q, augment and reset by hand
`timescale 1ns/1ps

module subword_alt_stage_tb;
	import subword_alt_pkg::*;

	// ==========================================================
	// signals
	typedef struct packed {
		op_e         op;     // indirection op under test
		logic        single; // single-operand form
		logic [31:0] src;    // base and auto-index
		logic [31:0] dst;    // pointer value
		logic [8:0]  addr;   // expected substituted address
		logic [2:0]  sel;    // expected selector
		field_e      kind;   // expected sub-field kind
		logic [4:0]  shift;  // expected bit offset
		logic [31:0] wb;     // expected post-adjusted pointer
	} row_s;
	logic       clk;
	logic       rst;
	logic       issueValid;
	logic       issueReady;
	logic       execValid;
	logic       irqBlock;
	instr_s     issueInstr;
	exec_s      execInstr;
	exec_s      lastExec;
	wb_s        wbOut;
	wb_s        lastWb;
	logic [7:0] execCount;
	logic [7:0] wbCount;
	int         failures;
	int         cmpCount;
	row_s       rows [7];

	// ==========================================================
	// instances
	subword_alt_stage i_dut (.clk(clk), .rst(rst), .issueValid(issueValid),
		.issueInstr(issueInstr), .issueReady(issueReady), .execValid(execValid),
		.execInstr(execInstr), .wbOut(wbOut), .irqBlock(irqBlock));
	exec_model i_exec (.clk(clk), .rst(rst), .execValid(execValid), .execInstr(execInstr),
		.wbOut(wbOut), .lastExec(lastExec), .lastWb(lastWb), .execCount(execCount),
		.wbCount(wbCount));

	// free-running core clock, 25 ns period
	always #12.5 clk = ~clk;

	// ==========================================================
	// helpers
	function automatic instr_s mk(op_e op, logic s, logic lit, logic [8:0] da,
		logic [8:0] df, logic [31:0] dv, logic [31:0] sv);
		mk = '{op, s, lit, da, df, dv, sv};
	endfunction

	// case inequality so an unknown never passes
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (failures == 0 && cmpCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// called at a falling edge; holds the request until an edge with ready high
	task automatic issue(input instr_s i);
		int n;
		n = 0;
		issueValid = 1'b1;
		issueInstr = i;
		while (issueReady !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n == 50) begin
			failures++;
			end_of_test();
		end
		@(posedge clk);
		@(negedge clk);
	endtask

	// drop the request and let cycles pass
	task automatic idle(input int c);
		issueValid = 1'b0;
		repeat (c) @(negedge clk);
	endtask

	// ==========================================================
	// watchdog: the tests need well under a thousand cycles
	initial begin
		#500000;
		failures++;
		end_of_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		issueValid = 1'b0;
		issueInstr = '0;
		failures = 0;
		cmpCount = 0;
		rows[0] = '{OP_ALTER_BYTE, 1'b0, 32'h0000_0220, 32'h0000_0017, 9'h025, 3'h3,
			FLD_BYTE, 5'h18, 32'h0000_0018};
		rows[1] = '{OP_ALTER_BYTE, 1'b1, 32'h0000_0220, 32'h0000_07fe, 9'h1ff, 3'h2,
			FLD_BYTE, 5'h10, 32'h0000_07fe};
		rows[2] = '{OP_ALTER_NIBBLE, 1'b0, 32'h0003_fff0, 32'h0000_004f, 9'h1f9, 3'h7,
			FLD_NIBBLE, 5'h1c, 32'h0000_004e};
		rows[3] = '{OP_ALTER_NIBBLE, 1'b1, 32'h0003_fff0, 32'h0000_0ffa, 9'h1ff, 3'h2,
			FLD_NIBBLE, 5'h08, 32'h0000_0ffa};
		rows[4] = '{OP_ALTER_WORD, 1'b0, 32'h0000_05ff, 32'h0000_0007, 9'h002, 3'h1,
			FLD_WORD, 5'h10, 32'h0000_0009};
		rows[5] = '{OP_ALTER_WORD, 1'b1, 32'h0000_05ff, 32'h0000_0002, 9'h001, 3'h0,
			FLD_WORD, 5'h00, 32'h0000_0002};
		// negative index below zero: the sum is not wrapped to the pointer width
		rows[6] = '{OP_ALTER_BYTE, 1'b0, 32'h0003_fe00, 32'h0000_0000, 9'h000, 3'h0,
			FLD_BYTE, 5'h00, 32'hffff_ffff};
		repeat (20) @(negedge clk);
		rst = 1'b0;
		// table: indirection op, then a plain instruction that gets retargeted
		for (int k = 0; k < 7; k++) begin
			issue(mk(rows[k].op, rows[k].single, 1'b0, 9'h010, 9'h000, rows[k].dst, rows[k].src));
			chk("issueReady", issueReady, 32'h0);
			chk("irqBusy", irqBlock, 32'h1);
			issue(mk(OP_OTHER, 1'b0, 1'b0, 9'h0aa, 9'h000, 32'h0, 32'h0));
			idle(3);
			chk("regAddr", lastExec.regAddr, rows[k].addr);
			chk("sel", lastExec.sel, rows[k].sel);
			chk("kind", lastExec.kind, rows[k].kind);
			chk("shift", lastExec.shift, rows[k].shift);
			chk("altered", lastExec.altered, 32'h1);
			chk("wbData", lastWb.data, rows[k].wb);
			chk("wbAddr", lastWb.addr, 9'h010);
			chk("wbCount", wbCount, 32'(k + 1));
			chk("irqAfter", irqBlock, 32'h0);
		end
		// pending q survives an indirection op, then one instruction only
		issue(mk(OP_LOAD_Q, 1'b0, 1'b0, 9'h000, 9'h000, 32'h1234_5678, 32'h0));
		issue(mk(rows[4].op, 1'b0, 1'b0, 9'h010, 9'h000, rows[4].dst, rows[4].src));
		issue(mk(OP_OTHER, 1'b0, 1'b0, 9'h0aa, 9'h000, 32'h0, 32'h0));
		idle(3);
		chk("qValid", lastExec.qValid, 32'h1);
		chk("qVal", lastExec.qVal, 32'h1234_5678);
		issue(mk(OP_OTHER, 1'b0, 1'b0, 9'h0bb, 9'h000, 32'h0, 32'h0));
		idle(3);
		chk("alteredOnce", lastExec.altered, 32'h0);
		chk("regAddrOwn", lastExec.regAddr, 9'h0bb);
		chk("qGone", lastExec.qValid, 32'h0);
		// augment skips a non-literal user and is spent by the literal one
		issue(mk(OP_EXTEND_DEST, 1'b0, 1'b0, 9'h000, 9'h000, 32'h0, 32'habcd_e000));
		chk("irqAug", irqBlock, 32'h1);
		issue(mk(OP_OTHER, 1'b0, 1'b0, 9'h0cc, 9'h000, 32'h0, 32'h0));
		idle(2);
		chk("irqHeld", irqBlock, 32'h1);
		issue(mk(OP_OTHER, 1'b0, 1'b1, 9'h0cc, 9'h155, 32'h0, 32'h0));
		idle(3);
		chk("destLit", lastExec.destLit, 32'habcd_e155);
		chk("irqFree", irqBlock, 32'h0);
		issue(mk(OP_OTHER, 1'b0, 1'b1, 9'h0cc, 9'h0aa, 32'h0, 32'h0));
		idle(3);
		chk("destLitPlain", lastExec.destLit, 32'h0000_00aa);
		// reset in the middle of an indirection op drops the substitution
		issue(mk(rows[0].op, 1'b0, 1'b0, 9'h010, 9'h000, rows[0].dst, rows[0].src));
		rst = 1'b1;
		idle(1);
		chk("rstReady", issueReady, 32'h1);
		chk("rstIrq", irqBlock, 32'h0);
		chk("rstExec", execValid, 32'h0);
		chk("rstWb", wbOut.valid, 32'h0);
		rst = 1'b0;
		issue(mk(OP_OTHER, 1'b0, 1'b0, 9'h0dd, 9'h000, 32'h0, 32'h0));
		idle(3);
		chk("rstAltered", lastExec.altered, 32'h0);
		chk("rstRegAddr", lastExec.regAddr, 9'h0dd);
		end_of_test();
	end
endmodule
